// file: hdl/pvip_sink.sv
// Video input port, device end: samples the link, decodes formats,
// applies the frame mask and halts the sequencer on lost vsync.
// Assumes link signals are asynchronous to i_clk and that the pixel
// clock is much slower than i_clk, so it is sampled, not used as clock.
//
// Contract
// - Source keeps vsync running during operation
// - Lost vsync halts sequencer, LEDs off
// - Active mask blocks frames, holds image
// - Mask polarity programmable, resets active high
// - Unused mask tied low by source
// - Mask changes only in vertical blanking
// - Accept 24-bit pixels on 24 wires
// - Accept 18-bit pixels on 18 wires
// - 4:2:2 pairs share even chroma sample
// - Sync polarities are configurable
// - Port has syncs, valid, bus, clock, mask
// - Landscape only, no rotation
// - Source stays within interface limits
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pvip_sink #(
  parameter int unsigned VS_TIMEOUT_CYC = pvip_pkg::VS_TIMEOUT_CYC_DEF
) (
  input wire logic i_clk,
  input wire logic i_srst,
  pvip_if.sink link,
  input wire logic [pvip_pkg::ADDR_W-1:0] i_addr,
  input wire logic [pvip_pkg::REG_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [pvip_pkg::REG_W-1:0] o_rdata,
  output logic o_pix_valid,
  output logic [pvip_pkg::DATA_W-1:0] o_pix_data,
  output logic o_pix_sof,
  output logic o_pix_sol,
  output logic o_seq_run,
  output logic o_led_en,
  output logic o_frame_hold
);
  import pvip_pkg::*;

  localparam int unsigned SYNC_W = DATA_W + 5;

  function automatic logic [7:0] expand6(input logic [5:0] v);
    expand6 = {v, v[5:4]};
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser for every link wire
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {link.pclk, link.vsync, link.hsync, link.pixel_valid_in,
                  link.frame_update_mask, link.pixel_bus};
      sync2_q <= sync1_q;
    end
  end

  logic s_pclk;
  logic s_vs;
  logic s_hs;
  logic s_de;
  logic s_mask;
  logic [DATA_W-1:0] s_bus;
  assign {s_pclk, s_vs, s_hs, s_de, s_mask, s_bus} = sync2_q;

  //////////////////////////////////////////////////////////////////////
  // Control register
  logic [CTRL_W-1:0] ctrl_q;
  pvip_fmt_type fmt;
  logic vs_high;
  logic hs_high;
  logic mask_low;
  logic enable;
  assign fmt = pvip_fmt_type'(ctrl_q[CTRL_FMT_LSB +: 2]);
  assign vs_high = ctrl_q[CTRL_VS_HIGH];
  assign hs_high = ctrl_q[CTRL_HS_HIGH];
  assign mask_low = ctrl_q[CTRL_MASK_LOW];
  assign enable = ctrl_q[CTRL_ENABLE];

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctrl_q <= CTRL_RST;
    end else if (i_wr && i_addr == REG_CTRL) begin
      ctrl_q <= i_wdata[CTRL_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pixel clock edge and sync edges
  logic pclk_prev_q;
  logic vs_prev_q;
  logic hs_prev_q;
  logic pe;
  logic vs_act;
  logic hs_act;
  logic mask_act;
  logic frame_start;
  logic line_start;

  assign pe = s_pclk & ~pclk_prev_q;
  assign vs_act = vs_high ? s_vs : ~s_vs;
  assign hs_act = hs_high ? s_hs : ~s_hs;
  assign mask_act = mask_low ? ~s_mask : s_mask;
  assign frame_start = pe & vs_act & ~vs_prev_q;
  assign line_start = pe & hs_act & ~hs_prev_q;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pclk_prev_q <= 1'b0;
      vs_prev_q <= 1'b0;
      hs_prev_q <= 1'b0;
    end else begin
      pclk_prev_q <= s_pclk;
      if (pe) begin
        vs_prev_q <= vs_act;
        hs_prev_q <= hs_act;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Vsync watchdog and sequencer run state
  logic [31:0] vs_cnt_q;
  logic run_q;
  logic lost_q;
  logic timeout;
  logic lost_clr;
  assign timeout = (vs_cnt_q >= VS_TIMEOUT_CYC - 1);
  assign lost_clr = i_wr && i_addr == REG_STATUS && i_wdata[STAT_LOST];

  always_ff @(posedge i_clk) begin
    if (i_srst || frame_start) begin
      vs_cnt_q <= '0;
    end else if (!timeout) begin
      vs_cnt_q <= vs_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      run_q <= 1'b0;
    end else if (!enable || (timeout && !frame_start)) begin
      run_q <= 1'b0;
    end else if (frame_start) begin
      run_q <= 1'b1;
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      lost_q <= 1'b0;
    end else if (run_q && timeout && !frame_start) begin
      lost_q <= 1'b1;
    end else if (lost_clr) begin
      lost_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Frame mask, latched at frame start; legal since it only moves
  // in blanking, and it keeps a frame from being cut in half
  logic hold_q;
  logic [FCNT_W-1:0] fcnt_q;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      hold_q <= 1'b0;
    end else if (frame_start) begin
      hold_q <= mask_act;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      fcnt_q <= '0;
    end else if (frame_start) begin
      fcnt_q <= fcnt_q + 16'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pixel decode
  logic take;
  logic odd_q;
  logic pend_q;
  logic [7:0] y0_q;
  logic [7:0] y1_q;
  logic [7:0] cb_q;
  logic [7:0] cr_q;

  // only valid words of unmasked frames
  assign take = pe & s_de & run_q & ~hold_q;

  // even pixel keeps Cb, odd supplies Cr
  always_ff @(posedge i_clk) begin
    if (i_srst || line_start) begin
      odd_q <= 1'b0;
      pend_q <= 1'b0;
      y0_q <= 8'h00;
      y1_q <= 8'h00;
      cb_q <= 8'h00;
      cr_q <= 8'h00;
    end else begin
      pend_q <= 1'b0;
      if (take && fmt == PVIP_FMT_422) begin
        if (!odd_q) begin
          y0_q <= s_bus[15:8];
          cb_q <= s_bus[7:0];
          odd_q <= 1'b1;
        end else begin
          y1_q <= s_bus[15:8];
          cr_q <= s_bus[7:0];
          pend_q <= 1'b1;
          odd_q <= 1'b0;
        end
      end
    end
  end

  // pixels leave in arrival order, no rotation
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pix_valid <= 1'b0;
      o_pix_data <= '0;
    end else begin
      o_pix_valid <= 1'b0;
      if (pend_q) begin
        o_pix_valid <= 1'b1;
        o_pix_data <= {y1_q, cb_q, cr_q};
      end else if (take) begin
        unique case (fmt)
          PVIP_FMT_24: begin
            o_pix_valid <= 1'b1;
            o_pix_data <= s_bus;
          end
          // low 18 wires, widened to 8 bits
          PVIP_FMT_18: begin
            o_pix_valid <= 1'b1;
            o_pix_data <= {expand6(s_bus[17:12]), expand6(s_bus[11:6]),
                           expand6(s_bus[5:0])};
          end
          PVIP_FMT_422: begin
            o_pix_valid <= odd_q;
            o_pix_data <= {y0_q, cb_q, s_bus[7:0]};
          end
          default: begin
            o_pix_valid <= 1'b0;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Status outputs and read port
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pix_sof <= 1'b0;
      o_pix_sol <= 1'b0;
      o_seq_run <= 1'b0;
      o_led_en <= 1'b0;
      o_frame_hold <= 1'b0;
    end else begin
      // Enable, not run_q: the frame that starts the sequencer counts
      o_pix_sof <= frame_start & enable & ~mask_act;
      o_pix_sol <= line_start & run_q & ~hold_q;
      o_seq_run <= run_q;
      o_led_en <= run_q;
      o_frame_hold <= hold_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= '0;
      if (i_rd && i_addr == REG_CTRL) begin
        o_rdata <= {{(REG_W - CTRL_W){1'b0}}, ctrl_q};
      end else if (i_rd && i_addr == REG_STATUS) begin
        o_rdata <= {fcnt_q, 13'h0000, lost_q, hold_q, run_q};
      end
    end
  end

endmodule
`default_nettype wire

// file: hdl/pvip_pkg.sv
// Shared constants for the parallel video input port link.
// Assumes a 250 MHz system clock on both ends of the link.
package pvip_pkg;

  localparam int unsigned DATA_W = 24;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned REG_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;

  // Control field positions
  localparam int unsigned CTRL_FMT_LSB = 0;
  localparam int unsigned CTRL_VS_HIGH = 2;
  localparam int unsigned CTRL_HS_HIGH = 3;
  localparam int unsigned CTRL_MASK_LOW = 4;
  localparam int unsigned CTRL_ENABLE = 5;
  localparam int unsigned CTRL_W = 6;
  // Syncs active high, mask active high, format 24-bit, enabled
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h2C;

  // Status field positions
  localparam int unsigned STAT_RUN = 0;
  localparam int unsigned STAT_HOLD = 1;
  localparam int unsigned STAT_LOST = 2;
  localparam int unsigned STAT_FCNT_LSB = 16;
  localparam int unsigned FCNT_W = 16;

  typedef enum logic [1:0] {
    PVIP_FMT_24 = 2'b00,
    PVIP_FMT_18 = 2'b01,
    PVIP_FMT_422 = 2'b10
  } pvip_fmt_type;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned PCLK_PERIOD_NS = 160;
  localparam int unsigned PCLK_HALF_CYC = PCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int unsigned VS_TIMEOUT_MS = 25;
  localparam int unsigned VS_TIMEOUT_CYC_DEF =
    VS_TIMEOUT_MS * (1000000 / CLK_PERIOD_NS);

endpackage

// file: hdl/pvip_if.sv
// Link wires between a video source and the video input port.
// All signals are driven by the source; the sink only reads them.
`timescale 1ns/1ps
`default_nettype none
interface pvip_if;
  logic pclk;
  logic vsync;
  logic hsync;
  logic pixel_valid_in;
  logic [23:0] pixel_bus;
  logic frame_update_mask;

  modport source (
    output pclk,
    output vsync,
    output hsync,
    output pixel_valid_in,
    output pixel_bus,
    output frame_update_mask
  );

  modport sink (
    input pclk,
    input vsync,
    input hsync,
    input pixel_valid_in,
    input pixel_bus,
    input frame_update_mask
  );
endinterface
`default_nettype wire

// file: hdl/pvip_source.sv
// Video input port, source end: makes the pixel clock by division
// and launches user timing and pixels on its falling edge.
// Assumes the user drives syncs, valid, data and mask on i_clk and
// holds them until o_take pulses.
`timescale 1ns/1ps
`default_nettype none
module pvip_source #(
  parameter int unsigned HALF_CYC = pvip_pkg::PCLK_HALF_CYC,
  parameter bit MASK_USED = 1'b1,
  parameter bit VS_ACTIVE_HIGH = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_srst,
  pvip_if.source link,
  input wire logic i_vsync,
  input wire logic i_hsync,
  input wire logic i_valid,
  input wire logic [pvip_pkg::DATA_W-1:0] i_data,
  input wire logic i_mask,
  output logic o_take
);
  import pvip_pkg::*;

  logic [15:0] div_q;
  logic pclk_q;
  logic wrap;
  logic fall;
  // divider sets the clock rate; keep HALF_CYC within limits
  assign wrap = (div_q == 16'(HALF_CYC - 1));
  assign fall = wrap & pclk_q;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      div_q <= 16'h0000;
      pclk_q <= 1'b0;
    end else if (wrap) begin
      div_q <= 16'h0000;
      pclk_q <= ~pclk_q;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Launch on the falling edge, so data is stable at the rising edge
  logic vs_q;
  logic hs_q;
  logic de_q;
  logic [DATA_W-1:0] bus_q;
  logic mask_q;
  logic vs_blank;
  // Judged on the incoming word, so the mask moves with vsync itself
  assign vs_blank = VS_ACTIVE_HIGH ? i_vsync : ~i_vsync;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      vs_q <= ~VS_ACTIVE_HIGH;
      hs_q <= 1'b0;
      de_q <= 1'b0;
      bus_q <= '0;
      o_take <= 1'b0;
    end else begin
      o_take <= fall;
      if (fall) begin
        vs_q <= i_vsync;
        hs_q <= i_hsync;
        de_q <= i_valid;
        bus_q <= i_data;
      end
    end
  end

  // mask low when unused, moved only in blanking
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mask_q <= 1'b0;
    end else if (fall && vs_blank && MASK_USED) begin
      mask_q <= i_mask;
    end
  end

  assign link.pclk = pclk_q;
  assign link.vsync = vs_q;
  assign link.hsync = hs_q;
  assign link.pixel_valid_in = de_q;
  assign link.pixel_bus = bus_q;
  assign link.frame_update_mask = mask_q;

endmodule
`default_nettype wire

// file: verification/pvip_checker.sv
// Link checker: pixel clock shape and launch timing of link wires.
// Assumes every link wire is launched by the source on a pclk fall.
`timescale 1ns/1ps
`default_nettype none
module pvip_checker #(
  parameter int HALF = 20
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic pclk,
  input wire logic vsync,
  input wire logic hsync,
  input wire logic pixel_valid_in,
  input wire logic [23:0] pixel_bus,
  input wire logic frame_update_mask
);
  int run_q;
  logic last_q;
  logic seen_q;
  logic edge_w;

  assign edge_w = pclk != last_q;

  // First level after reset is partial, so it is not judged
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      run_q <= 0;
      last_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      last_q <= pclk;
      run_q <= edge_w ? 1 : run_q + 1;
      if (edge_w) begin
        seen_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  property p_high_len;
    (seen_q && edge_w && !pclk) |-> run_q == HALF;
  endproperty
  a_high_len: assert property (p_high_len)
    else $error("pclk high time wrong");

  property p_low_len;
    (seen_q && edge_w && pclk) |-> run_q == HALF;
  endproperty
  a_low_len: assert property (p_low_len)
    else $error("pclk low time wrong");

  property p_max_len;
    seen_q |-> run_q <= HALF;
  endproperty
  a_max_len: assert property (p_max_len)
    else $error("pclk stalled");

  property p_bus;
    $changed(pixel_bus) |-> $fell(pclk);
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus moved off pclk fall");

  property p_valid;
    !$stable(pixel_valid_in) |-> !pclk && $past(pclk);
  endproperty
  a_valid: assert property (p_valid)
    else $error("valid moved off pclk fall");

  property p_hsync;
    $rose(pclk) |-> $stable(hsync);
  endproperty
  a_hsync: assert property (p_hsync)
    else $error("hsync moved at pclk rise");

  property p_vsync;
    $changed(vsync) |-> edge_w && !pclk;
  endproperty
  a_vsync: assert property (p_vsync)
    else $error("vsync moved off pclk fall");

  property p_mask;
    $changed(frame_update_mask) |-> vsync && $fell(pclk);
  endproperty
  a_mask: assert property (p_mask)
    else $error("mask moved outside blanking");

  c_pix: cover property (seen_q && $rose(pclk) && pixel_valid_in);
  c_mask: cover property ($changed(frame_update_mask));
  c_frame: cover property ($rose(vsync));
endmodule
`default_nettype wire

// file: verification/test_parallel_video_input_port.sv
// Bench: source and sink joined by the link, frames in every format.
// Assumes the short vsync watchdog set below exceeds one bench frame.
`timescale 1ns/1ps
`default_nettype none
module test_parallel_video_input_port;
  import pvip_pkg::*;
  localparam int TO = 2000;
  logic i_clk, i_srst, w_s, r_s, vs, hs, val, msk;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  logic [23:0] dat, pd;
  logic take, pv, sof, sol, run, led, hold;
  int err_count = 0, comparisons = 0, seed = 32'h6D094DD1, cyc = 0;
  int sof_n, sol_n, sof_c, exp_gap;
  bit want_gap;
  logic [23:0] q[$];
  logic [4:0] tc [8] = '{5'h04, 5'h05, 5'h0C, 5'h14, 5'h1C, 5'h06,
    5'h07, 5'h00};

  pvip_if link();
  pvip_source u_pvip_source (.i_clk(i_clk), .i_srst(i_srst),
    .link(link), .i_vsync(vs), .i_hsync(hs), .i_valid(val),
    .i_data(dat), .i_mask(msk), .o_take(take));
  pvip_sink #(.VS_TIMEOUT_CYC(TO)) u_pvip_sink (.i_clk(i_clk),
    .i_srst(i_srst), .link(link), .i_addr(addr), .i_wdata(wdata),
    .i_wr(w_s), .i_rd(r_s), .o_rdata(rdata), .o_pix_valid(pv),
    .o_pix_data(pd), .o_pix_sof(sof), .o_pix_sol(sol),
    .o_seq_run(run), .o_led_en(led), .o_frame_hold(hold));
  pvip_checker #(.HALF(PCLK_HALF_CYC)) u_pvip_checker (.i_clk(i_clk),
    .i_srst(i_srst), .pclk(link.pclk), .vsync(link.vsync),
    .hsync(link.hsync), .pixel_valid_in(link.pixel_valid_in),
    .pixel_bus(link.pixel_bus),
    .frame_update_mask(link.frame_update_mask));

  ////////////////////////////////////////////////////////////
  task automatic check(string n, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask

  task automatic close_out;
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic reg_wr(logic [3:0] a, logic [31:0] d);
    @(posedge i_clk);
    w_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge i_clk);
    w_s <= 1'b0;
  endtask

  task automatic reg_rd(logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    r_s <= 1'b1;
    addr <= a;
    @(posedge i_clk);
    r_s <= 1'b0;
    #1 d = rdata;
  endtask

  // Sampled at the fall so the pulse is settled; returns on a rise
  task automatic wait_take;
    int n;
    for (n = 0; n < 100; n++) begin
      @(negedge i_clk);
      if (take === 1'b1) break;
    end
    if (n == 100) check("take", 0, 1);
    @(posedge i_clk);
  endtask

  task automatic put(logic v, logic h, logic d, logic [23:0] x, logic m);
    vs <= v;
    hs <= h;
    val <= d;
    dat <= x;
    msk <= m;
    wait_take();
  endtask

  task automatic frame(logic [1:0] f, logic vh, logic ml, logic m);
    logic [23:0] d, e;
    bit held;
    held = m ^ ml;
    e = 24'h0;
    // hsync polarity follows vsync polarity here
    reg_wr(REG_CTRL, {26'h0, 1'b1, ml, vh, vh, f});
    // A polarity change can fake one sync edge; let it pass
    wait_take();
    wait_take();
    sof_n = 0;
    sol_n = 0;
    want_gap = 0;
    exp_gap = (vh ? 80 : 40) + (f == PVIP_FMT_422 ? 40 : 0);
    put(1'b1, 1'b0, 1'b0, 24'h0, m);
    for (int l = 0; l < 2; l++) begin
      put(1'b0, 1'b1, 1'b0, 24'h0, m);
      for (int p = 0; p < 4; p++) begin
        d = 24'($random(seed));
        if (!held && f == PVIP_FMT_24) q.push_back(d);
        if (!held && f == PVIP_FMT_18)
          q.push_back({d[17:12], d[17:16], d[11:6], d[11:10], d[5:0],
            d[5:4]});
        // Odd pixel reuses the even pixel's Cb
        if (!held && f == PVIP_FMT_422 && p[0]) begin
          q.push_back({e[15:8], e[7:0], d[7:0]});
          q.push_back({d[15:8], e[7:0], d[7:0]});
        end
        e = d;
        put(1'b0, 1'b0, 1'b1, d, m);
      end
    end
    put(1'b0, 1'b0, 1'b0, 24'h0, m);
    repeat (60) @(posedge i_clk);
    @(negedge i_clk);
    check("sof", sof_n, !held);
    check("sol", sol_n, held ? 0 : 2);
    check("left", q.size(), 0);
    check("hold", hold, held);
    check("run", run, 1);
    check("led", led, 1);
  endtask

  ////////////////////////////////////////////////////////////
  always @(negedge i_clk) begin
    cyc++;
    if (sof === 1'b1) begin
      sof_n++;
      sof_c = cyc;
      want_gap = 1;
    end
    if (sol === 1'b1) sol_n++;
    if (pv === 1'b1) begin
      if (want_gap) check("gap", cyc - sof_c, exp_gap);
      want_gap = 0;
      if (q.size() == 0) check("extra", 1, 0);
      else check("pixel", pd, q.pop_front());
    end
  end

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  initial begin
    repeat (30000) @(posedge i_clk);
    err_count++;
    close_out();
  end

  initial begin
    logic [31:0] r;
    logic [15:0] fc;
    i_srst = 1'b1;
    w_s = 1'b0;
    r_s = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    {vs, hs, val, msk} = 4'h0;
    dat = 24'h0;
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    reg_rd(REG_CTRL, r);
    check("ctrl", r, 32'h0000002C);
    reg_rd(4'hC, r);
    check("unmapped", r, 32'h0);
    check("run0", run, 0);
    foreach (tc[i]) frame(tc[i][4:3], tc[i][2], tc[i][1], tc[i][0]);
    // No frame starts: watchdog must stop the sequencer
    repeat (TO + 200) @(posedge i_clk);
    @(negedge i_clk);
    check("run", run, 0);
    check("led", led, 0);
    reg_rd(REG_STATUS, r);
    check("lost", r[2:0], 3'b100);
    reg_wr(REG_STATUS, 32'h4);
    reg_rd(REG_STATUS, r);
    check("clear", r[2], 0);
    fc = r[31:16];
    frame(PVIP_FMT_24, 1'b1, 1'b0, 1'b0);
    check("rerun", run, 1);
    reg_rd(REG_STATUS, r);
    check("fcnt", r[31:16], fc + 16'h1);
    check("status", r[2:0], 3'b001);
    close_out();
  end
endmodule
`default_nettype wire
